/* nlt_pkg.sv */
// constants, types and register map of the nibble line transmitter
// Contract
// - each value is the time between two successive falling edges on the line.
// - every message starts with a calibration period of exactly 56 ticks.
// - a status nibble period of 12 to 27 ticks follows calibration.
// - one to six data nibble periods follow, count set by the nibble count field.
// - a checksum nibble period of 12 to 27 ticks ends the data part.
// - buffer bits 31:28 status, 27:24 checksum, 23:20 first data nibble.
// - further data nibbles come from lower buffer nibbles, sent only if count allows.
// - buffer checksum field is sent only when bypass is set, else ignored.
// - without bypass hardware computes recommended or legacy checksum by legacy select.
// - with includes-status set the status nibble is folded into the checksum.
// - after reset the block is in init, disabled, configuration writable, flags reset.
// - init is left for idle when init bit clear and enable set, one write allowed.
// - outside init, divider and configuration are read-only except the init bit.
// - idle waits for software to clear buffer-empty, then transmits.
// - single-shot returns to idle after a message if no new data.
// - otherwise missing data at calibration end aborts, flags under-run, enters error.
// - stop entry during transmit aborts, resets four flags, idles line, enters idle.
// - error state sends nothing until under-run cleared, then resets flags and idles.
// - setting init aborts, resets four flags; stays in error if under-run, else init.
// - tick comes from a 14-bit modulus counter: clock divided by divisor plus one.
// - buffer copied on the same clock edge as calibration's closing edge; buffer-empty set.
// - transmission-complete flag is set once the checksum nibble is sent.
// - calibration-start flag is set at the first falling edge of each message.
package nlt_pkg;
	localparam logic [7:0]  OFS_CONFIG   = 8'h00;
	localparam logic [7:0]  OFS_TICKDIV  = 8'h04;
	localparam logic [7:0]  OFS_FLAGS    = 8'h08;
	localparam logic [7:0]  OFS_TRANSMIT_MESSAGE_BUFFER    = 8'h0c;
	localparam logic [7:0]  OFS_STATUS   = 8'h10;
	localparam logic [5:0]  CAL_TICKS    = 6'h38;
	localparam logic [5:0]  NIB_BASE     = 6'h0c;
	localparam logic [5:0]  LOW_TICKS    = 6'h05;
	localparam logic [3:0]  SEG_CAL      = 4'h0;
	localparam logic [3:0]  SEG_STAT     = 4'h1;
	localparam logic [3:0]  SEG_FIRST_DATA_NIBBLE    = 4'h2;
	localparam logic [3:0]  SEG_CRC      = 4'h8;
	localparam logic [3:0]  CRC_SEED     = 4'h5;
	localparam logic [3:0]  CRC_POLY     = 4'hd;
	localparam logic [2:0]  MAX_NIB      = 3'h6;
	localparam logic [2:0]  MIN_NIB      = 3'h1;
	localparam int          TICKDIV_W    = 14;
	localparam logic [31:0] TRANSMIT_MESSAGE_BUFFER_RST    = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_IDLE = 2'b01,
		ST_TX   = 2'b10,
		ST_ERR  = 2'b11
	} nlt_state_t;

	typedef struct packed {
		logic       checksum_includes_status;
		logic       checksum_legacy_select;
		logic       checksum_bypass;
		logic [2:0] data_nibble_count;
		logic       single_shot;
		logic       transmitter_enable;
		logic       initialization_bit;
	} nlt_cfg_t;

	typedef struct packed {
		logic pause_rising_edge_flag;
		logic underrun_flag;
		logic cal_start_flag;
		logic transmission_complete_flag;
		logic buffer_empty_flag;
	} nlt_flags_t;

	localparam nlt_cfg_t   CFG_RST   = 9'h009;
	localparam nlt_flags_t FLAGS_RST = 5'h01;
endpackage

/* nlt_nibble_line_transmitter.sv */
// single-edge nibble line transmitter with apb register slave
`timescale 1ns/1ps
module nlt_nibble_line_transmitter
	import nlt_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              stop_req,
	output logic                   line_out
);

	nlt_state_t            state_ff, nxt_state;
	nlt_cfg_t              cfg_ff, nxt_cfg;
	nlt_flags_t            flags_ff, nxt_flags;
	logic [TICKDIV_W-1:0]  tick_div_ff, nxt_tick_div;
	logic [TICKDIV_W-1:0]  div_cnt_ff, nxt_div_cnt;
	logic [31:0]           transmit_message_buffer_ff, nxt_transmit_message_buffer;
	logic [31:0]           sh_ff, nxt_sh;
	logic [5:0]            tick_cnt_ff, nxt_tick_cnt;
	logic [3:0]            seg_ff, nxt_seg;
	logic [31:0]           prdata_ff, nxt_prdata;
	logic                  pready_ff, pslverr_ff, line_ff;

	// data nibble k (0..5) of a buffer image
	function automatic logic [3:0] data_nib(logic [31:0] b, int k);
		return b[(20 - 4 * k) +: 4];
	endfunction

	// out-of-range counts are clamped rather than refused
	function automatic logic [2:0] eff_cnt(logic [2:0] c);
		if (c < MIN_NIB) begin
			return MIN_NIB;
		end else if (c > MAX_NIB) begin
			return MAX_NIB;
		end
		return c;
	endfunction

	// table-free form of crc = nibble ^ table[crc]
	function automatic logic [3:0] crc_step(logic [3:0] c, logic [3:0] n);
		logic [3:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = {r[2:0], 1'b0} ^ (r[3] ? CRC_POLY : 4'h0);
		end
		return r ^ n;
	endfunction

	function automatic logic [3:0] crc_calc(logic [31:0] b, nlt_cfg_t c);
		logic [3:0] r;
		r = CRC_SEED;
		if (c.checksum_includes_status) begin
			r = crc_step(r, b[31:28]);
		end
		for (int k = 0; k < 6; k++) begin
			if (3'(k) < eff_cnt(c.data_nibble_count)) begin
				r = crc_step(r, data_nib(b, k));
			end
		end
		if (!c.checksum_legacy_select) begin
			r = crc_step(r, 4'h0);
		end
		return r;
	endfunction

	// bus decode
	wire        acc_phase = psel & penable & ~pready_ff;
	wire        wr_en     = psel & penable & pready_ff & pwrite;
	wire [7:0]  addr8     = 8'(paddr);
	wire        hit_cfg   = addr8 == OFS_CONFIG;
	wire        hit_div   = addr8 == OFS_TICKDIV;
	wire        hit_flags = addr8 == OFS_FLAGS;
	wire        hit_buf   = addr8 == OFS_TRANSMIT_MESSAGE_BUFFER;
	wire        hit_stat  = addr8 == OFS_STATUS;
	wire        hit_any   = hit_cfg | hit_div | hit_flags | hit_buf | hit_stat;
	wire        in_init   = state_ff == ST_INIT;
	wire        fl_wr     = wr_en & hit_flags & ~cfg_ff.initialization_bit
	                        & cfg_ff.transmitter_enable;
	wire [4:0]  clr_bits  = fl_wr ? pwdata[4:0] : 5'h00;

	// line engine
	wire [2:0]  n_cnt     = eff_cnt(cfg_ff.data_nibble_count);
	wire [3:0]  last_data = SEG_FIRST_DATA_NIBBLE + {1'b0, n_cnt} - 4'h1;
	wire [3:0]  crc_val   = cfg_ff.checksum_bypass ? sh_ff[27:24] : crc_calc(sh_ff, cfg_ff);
	wire [3:0]  nib_cur   = (seg_ff == SEG_STAT) ? sh_ff[31:28] :
	                        (seg_ff == SEG_CRC)  ? crc_val :
	                        data_nib(sh_ff, int'(seg_ff - SEG_FIRST_DATA_NIBBLE));
	wire [5:0]  seg_len   = (seg_ff == SEG_CAL) ? CAL_TICKS : NIB_BASE + {2'b00, nib_cur};
	wire        in_tx     = state_ff == ST_TX;
	wire        tick      = div_cnt_ff == tick_div_ff;
	wire        seg_end   = in_tx & tick & (tick_cnt_ff == seg_len - 6'h01);
	wire        start_tx  = (state_ff == ST_IDLE) & ~flags_ff.buffer_empty_flag & ~stop_req;

	always_comb begin
		nxt_cfg      = cfg_ff;
		nxt_tick_div = tick_div_ff;
		nxt_transmit_message_buffer    = transmit_message_buffer_ff;
		if (wr_en && hit_cfg) begin
			if (in_init) begin
				nxt_cfg = nlt_cfg_t'(pwdata[8:0]);
			end else begin
				nxt_cfg.initialization_bit = pwdata[0];
			end
		end
		if (wr_en && hit_div && in_init) begin
			nxt_tick_div = pwdata[TICKDIV_W-1:0];
		end
		if (wr_en && hit_buf) begin
			nxt_transmit_message_buffer = pwdata;
		end
	end

	always_comb begin
		nxt_state    = state_ff;
		nxt_flags    = nlt_flags_t'(flags_ff & ~clr_bits);
		nxt_sh       = sh_ff;
		nxt_seg      = seg_ff;
		nxt_tick_cnt = tick_cnt_ff;
		nxt_div_cnt  = (in_tx && !tick) ? div_cnt_ff + 14'h0001 : 14'h0000;
		if (in_tx && tick) begin
			nxt_tick_cnt = tick_cnt_ff + 6'h01;
		end
		case (state_ff)
			ST_INIT: begin
				nxt_flags = FLAGS_RST;
				if (!cfg_ff.initialization_bit && cfg_ff.transmitter_enable) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (start_tx) begin
					nxt_state                = ST_TX;
					nxt_seg                  = SEG_CAL;
					nxt_tick_cnt             = 6'h00;
					nxt_flags.cal_start_flag = 1'b1;
				end
			end
			ST_TX: begin
				if (seg_end) begin
					nxt_tick_cnt = 6'h00;
					if (seg_ff == SEG_CAL) begin
						if (!flags_ff.buffer_empty_flag) begin
							nxt_sh                      = transmit_message_buffer_ff;
							nxt_flags.buffer_empty_flag = 1'b1;
							nxt_seg                     = SEG_STAT;
						end else begin
							nxt_flags.underrun_flag = 1'b1;
							nxt_state               = ST_ERR;
						end
					end else if (seg_ff == SEG_CRC) begin
						nxt_flags.transmission_complete_flag = 1'b1;
						if (flags_ff.buffer_empty_flag && cfg_ff.single_shot) begin
							nxt_state = ST_IDLE;
						end else begin
							nxt_seg                  = SEG_CAL;
							nxt_flags.cal_start_flag = 1'b1;
						end
					end else if (seg_ff == last_data) begin
						nxt_seg = SEG_CRC;
					end else begin
						nxt_seg = seg_ff + 4'h1;
					end
				end
				if (stop_req) begin
					nxt_state                            = ST_IDLE;
					nxt_flags                            = FLAGS_RST;
					nxt_flags.underrun_flag              = flags_ff.underrun_flag;
				end
			end
			default: begin
				if (clr_bits[3]) begin
					nxt_state = ST_IDLE;
					nxt_flags = FLAGS_RST;
				end
			end
		endcase
		if (cfg_ff.initialization_bit && !in_init) begin
			nxt_state               = flags_ff.underrun_flag ? ST_ERR : ST_INIT;
			nxt_flags               = FLAGS_RST;
			nxt_flags.underrun_flag = flags_ff.underrun_flag;
		end
	end

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (hit_cfg) begin
			nxt_prdata[8:0] = cfg_ff;
		end else if (hit_div) begin
			nxt_prdata[TICKDIV_W-1:0] = tick_div_ff;
		end else if (hit_flags) begin
			nxt_prdata[4:0] = flags_ff;
		end else if (hit_buf) begin
			nxt_prdata = transmit_message_buffer_ff;
		end else if (hit_stat) begin
			nxt_prdata[5:0] = {state_ff, seg_ff};
		end
	end

	// falling edge opens every period, line is low for the first ticks only
	wire nxt_line = ~((nxt_state == ST_TX) && (nxt_tick_cnt < LOW_TICKS));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff    <= ST_INIT;
			cfg_ff      <= CFG_RST;
			flags_ff    <= FLAGS_RST;
			tick_div_ff <= '0;
			div_cnt_ff  <= '0;
			transmit_message_buffer_ff    <= TRANSMIT_MESSAGE_BUFFER_RST;
			sh_ff       <= TRANSMIT_MESSAGE_BUFFER_RST;
			tick_cnt_ff <= 6'h00;
			seg_ff      <= SEG_CAL;
			line_ff     <= 1'b1;
		end else begin
			state_ff    <= nxt_state;
			cfg_ff      <= nxt_cfg;
			flags_ff    <= nxt_flags;
			tick_div_ff <= nxt_tick_div;
			div_cnt_ff  <= nxt_div_cnt;
			transmit_message_buffer_ff    <= nxt_transmit_message_buffer;
			sh_ff       <= nxt_sh;
			tick_cnt_ff <= nxt_tick_cnt;
			seg_ff      <= nxt_seg;
			line_ff     <= nxt_line;
		end
	end

	// one wait state: data and error are registered with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= acc_phase;
			pslverr_ff <= acc_phase & ~hit_any;
			prdata_ff  <= acc_phase ? nxt_prdata : 32'h0000_0000;
		end
	end

	assign prdata   = prdata_ff;
	assign pready   = pready_ff;
	assign pslverr  = pslverr_ff;
	assign line_out = line_ff;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_buffer_copy: assert property (
		seg_end && seg_ff == SEG_CAL && !flags_ff.buffer_empty_flag && !stop_req
		&& !cfg_ff.initialization_bit
		|=> seg_ff == SEG_STAT && flags_ff.buffer_empty_flag && sh_ff == $past(transmit_message_buffer_ff))
		else $error("buffer not copied at calibration end");
	a_nibble_len: assert property (
		in_tx && seg_ff != SEG_CAL |-> seg_len >= 6'd12 && seg_len <= 6'd27)
		else $error("nibble period out of range");
	a_cal_len: assert property (
		seg_end && seg_ff == SEG_CAL |-> tick_cnt_ff == 6'd55)
		else $error("calibration length wrong");
	a_edge_falls: assert property (
		seg_end && !stop_req && !cfg_ff.initialization_bit && nxt_state == ST_TX
		|=> !line_out ##1 (tick_div_ff != '0 || !line_out || !in_tx))
		else $error("no falling edge at period start");
	a_underrun_err: assert property (
		seg_end && seg_ff == SEG_CAL && flags_ff.buffer_empty_flag && !stop_req
		&& !cfg_ff.initialization_bit
		|=> state_ff == ST_ERR && flags_ff.underrun_flag && line_out)
		else $error("under-run not handled");
	a_complete_set: assert property (
		seg_end && seg_ff == SEG_CRC && !stop_req && !cfg_ff.initialization_bit
		|=> flags_ff.transmission_complete_flag)
		else $error("complete flag not set");
	a_start_flag: assert property (
		state_ff == ST_TX && $past(state_ff) == ST_IDLE |-> flags_ff.cal_start_flag && !line_out)
		else $error("calibration start not flagged");
	a_stop_abort: assert property (
		in_tx && stop_req && !cfg_ff.initialization_bit
		|=> state_ff == ST_IDLE && line_out && flags_ff.buffer_empty_flag)
		else $error("stop did not abort");
	a_error_quiet: assert property (
		state_ff == ST_ERR |-> line_out && tick_cnt_ff == 6'h00)
		else $error("line active in error state");
	a_config_lock: assert property (
		!in_init && $past(state_ff) != ST_INIT |-> $stable(tick_div_ff))
		else $error("divider changed outside init");
	a_bypass_crc: assert property (
		seg_ff == SEG_CRC && cfg_ff.checksum_bypass |-> nib_cur == sh_ff[27:24])
		else $error("bypass checksum not sent");
	a_init_enter: assert property (
		cfg_ff.initialization_bit && !in_init && !flags_ff.underrun_flag
		|=> state_ff == ST_INIT ##1 flags_ff == FLAGS_RST)
		else $error("init not entered");

	// state walk; stop overrides the idle and transmit steps and a set init bit every step, so they are left out
	a_init_quiet: assert property (
		in_init |-> line_out && flags_ff == FLAGS_RST)
		else $error("init state not quiet");
	a_init_leave: assert property (
		in_init && !cfg_ff.initialization_bit && cfg_ff.transmitter_enable
		|=> state_ff == ST_IDLE)
		else $error("init not left");
	a_idle_start: assert property (
		state_ff == ST_IDLE && !flags_ff.buffer_empty_flag && !stop_req
		&& !cfg_ff.initialization_bit |=> in_tx && !line_out)
		else $error("idle did not start");
	a_idle_wait: assert property (
		state_ff == ST_IDLE && flags_ff.buffer_empty_flag |=> !in_tx)
		else $error("started without data");
	a_error_leave: assert property (
		state_ff == ST_ERR && clr_bits[3] |=> state_ff == ST_IDLE && flags_ff == FLAGS_RST)
		else $error("error state not left");
	a_error_stay: assert property (
		state_ff == ST_ERR && !clr_bits[3] |=> state_ff == ST_ERR && line_out)
		else $error("error state left early");
	a_init_error: assert property (
		cfg_ff.initialization_bit && !in_init && flags_ff.underrun_flag
		|=> state_ff == ST_ERR && line_out)
		else $error("under-run lost on init");
	a_cfg_lock: assert property (
		!in_init && $past(state_ff) != ST_INIT |-> $stable(cfg_ff[8:1]))
		else $error("configuration changed outside init");

	// segment order inside one message
	a_status_next: assert property (
		seg_end && seg_ff == SEG_STAT && !stop_req && !cfg_ff.initialization_bit
		|=> seg_ff == SEG_FIRST_DATA_NIBBLE)
		else $error("data does not follow status");
	a_data_count: assert property (
		in_tx && seg_ff >= SEG_FIRST_DATA_NIBBLE && seg_ff < SEG_CRC
		|-> seg_ff - SEG_FIRST_DATA_NIBBLE < {1'b0, n_cnt})
		else $error("too many data nibbles");
	a_crc_follows: assert property (
		seg_end && seg_ff == last_data && !stop_req && !cfg_ff.initialization_bit
		|=> seg_ff == SEG_CRC)
		else $error("checksum does not follow data");
	a_single_stop: assert property (
		seg_end && seg_ff == SEG_CRC && cfg_ff.single_shot && flags_ff.buffer_empty_flag
		&& !stop_req && !cfg_ff.initialization_bit |=> state_ff == ST_IDLE && line_out)
		else $error("single shot did not return to idle");
	a_next_message: assert property (
		seg_end && seg_ff == SEG_CRC
		&& !(cfg_ff.single_shot && flags_ff.buffer_empty_flag)
		&& !stop_req && !cfg_ff.initialization_bit
		|=> in_tx && seg_ff == SEG_CAL && flags_ff.cal_start_flag && !line_out)
		else $error("next calibration not started");
	a_first_data: assert property (
		in_tx && seg_ff == SEG_FIRST_DATA_NIBBLE |-> nib_cur == sh_ff[23:20])
		else $error("first data nibble wrong");
	a_last_data: assert property (
		in_tx && seg_ff == SEG_FIRST_DATA_NIBBLE + 4'h5 |-> nib_cur == sh_ff[3:0])
		else $error("sixth data nibble wrong");

	// tick generator and pulse shape
	a_div_range: assert property (
		div_cnt_ff <= tick_div_ff)
		else $error("divider counter past modulus");
	a_tick_count: assert property (
		in_tx && tick && !seg_end && !stop_req && !cfg_ff.initialization_bit
		|=> tick_cnt_ff == $past(tick_cnt_ff) + 6'h01)
		else $error("tick not counted");
	a_low_width: assert property (
		in_tx |-> line_out == (tick_cnt_ff >= LOW_TICKS))
		else $error("line level wrong inside period");

	c_underrun: cover property (state_ff == ST_TX ##1 state_ff == ST_ERR);
	c_complete: cover property (seg_end && seg_ff == SEG_CRC);
	c_six_nibbles: cover property (seg_end && seg_ff == SEG_FIRST_DATA_NIBBLE + 4'h5);
	c_single_idle: cover property (state_ff == ST_TX ##1 state_ff == ST_IDLE && !stop_req);
	c_stop_abort: cover property (in_tx && stop_req);

endmodule

/* nlt_rx_model.sv */
// receiver model: logs the clock count between falling edges of the line
`timescale 1ns/1ps
module nlt_rx_model (
	input wire logic pclk,
	input wire logic clr,
	input wire logic line_in
);
	int   per_q[$];
	int   cnt_ff;
	logic seen_ff;
	logic prev_ff;
	initial begin
		cnt_ff = 0;
		seen_ff = 1'b0;
		prev_ff = 1'b1;
	end
	// a receiver only listens; the first fall only opens a period
	always @(posedge pclk) begin
		prev_ff <= line_in;
		cnt_ff <= cnt_ff + 1;
		if (clr) begin
			per_q.delete();
			seen_ff <= 1'b0;
		end else if (prev_ff && !line_in) begin
			if (seen_ff)
				per_q.push_back(cnt_ff);
			seen_ff <= 1'b1;
			cnt_ff <= 1;
		end
	end
endmodule

/* tb.sv */
// self-checking bench for the nibble line transmitter
`timescale 1ns/1ps
module tb;
	import nlt_pkg::*;
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        stop_req;
	logic        line_out;
	logic        clr;
	logic [31:0] rd;
	logic        rerr;
	int          exp_q[$];
	int          errors;
	int          samples_checked;
	int          cycles;

	nlt_nibble_line_transmitter i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stop_req(stop_req), .line_out(line_out));
	nlt_rx_model i_rx (.pclk(pclk), .clr(clr), .line_in(line_out));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic report_and_stop();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	// only the cycle ceiling ends a wait for pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_flag(input logic [31:0] m);
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_FLAGS, 32'h0);
			n++;
		end while ((rd & m) !== m && n < 500);
		chk(rd & m, m);
	endtask

	function automatic logic [3:0] mul16(input logic [3:0] c);
		logic [7:0] v;
		v = {c, 4'h0};
		for (int b = 7; b >= 4; b--) begin
			if (v[b])
				v = v ^ (8'h1d << (b - 4));
		end
		return v[3:0];
	endfunction

	// cfg: [8] status folded [7] legacy [6] bypass [5:3] count [2] single [1] enable
	task automatic push_msg(input logic [31:0] b, input logic [8:0] cfg, input int t);
		logic [3:0] c;
		c = CRC_SEED;
		exp_q.push_back(56 * t);
		exp_q.push_back((12 + b[31:28]) * t);
		if (cfg[8])
			c = mul16(c) ^ b[31:28];
		for (int i = 0; i < cfg[5:3]; i++) begin
			exp_q.push_back((12 + b[23-4*i -: 4]) * t);
			c = mul16(c) ^ b[23-4*i -: 4];
		end
		if (!cfg[7])
			c = mul16(c);
		if (cfg[6])
			c = b[27:24];
		exp_q.push_back((12 + c) * t);
	endtask

	task automatic setup(input logic [8:0] cfg, input logic [13:0] dv);
		apb(1'b1, OFS_TICKDIV, {18'h0, dv});
		apb(1'b1, OFS_CONFIG, {23'h0, cfg} | 32'h1);
		apb(1'b1, OFS_CONFIG, {23'h0, cfg});
		apb(1'b1, OFS_TICKDIV, 32'h0000_0007);
		apb(1'b0, OFS_TICKDIV, 32'h0);
		chk(rd, {18'h0, dv});
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
	endtask

	task automatic s_reset();
		apb(1'b0, OFS_CONFIG, 32'h0);
		chk(rd, 32'h0000_0009);
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, OFS_TRANSMIT_MESSAGE_BUFFER, 32'h0);
		chk(rd, TRANSMIT_MESSAGE_BUFFER_RST);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[5:4], 2'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(rerr, 1'b1);
		chk(rd, 32'h0);
		chk(line_out, 1'b1);
	endtask

	// whole messages, then starve the buffer so the run ends in under-run
	task automatic s_run(input logic [8:0] cfg, input logic [13:0] dv, input logic [31:0] b1,
		input logic [31:0] b2, input bit two);
		exp_q.delete();
		setup(cfg, dv);
		apb(1'b1, OFS_TRANSMIT_MESSAGE_BUFFER, b1);
		apb(1'b1, OFS_FLAGS, 32'h1);
		push_msg(b1, cfg, dv + 1);
		if (two) begin
			wait_flag(32'h1);
			apb(1'b1, OFS_TRANSMIT_MESSAGE_BUFFER, b2);
			apb(1'b1, OFS_FLAGS, 32'h1);
			push_msg(b2, cfg, dv + 1);
		end
		wait_flag(32'h8);
		chk(rd, 32'h0000_000f);
		chk(line_out, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[5:4], 2'h3);
		chk(i_rx.per_q.size(), exp_q.size());
		foreach (exp_q[i])
			chk(i_rx.per_q[i], exp_q[i]);
		apb(1'b1, OFS_FLAGS, 32'h8);
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[5:4], 2'h1);
		apb(1'b1, OFS_CONFIG, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[5:4], 2'h0);
	endtask

	task automatic s_stop();
		setup(9'h012, 14'h0);
		apb(1'b1, OFS_TRANSMIT_MESSAGE_BUFFER, 32'h5a3c_0000);
		apb(1'b1, OFS_FLAGS, 32'h1);
		wait_flag(32'h4);
		stop_req <= 1'b1;
		repeat (3) @(posedge pclk);
		stop_req <= 1'b0;
		chk(line_out, 1'b1);
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[5:4], 2'h1);
		apb(1'b1, OFS_CONFIG, 32'h1);
	endtask

	task automatic s_single();
		setup(9'h00e, 14'h0);
		apb(1'b1, OFS_TRANSMIT_MESSAGE_BUFFER, 32'h3c70_0000);
		apb(1'b1, OFS_FLAGS, 32'h1);
		wait_flag(32'h2);
		exp_q.delete();
		push_msg(32'h3c70_0000, 9'h00e, 1);
		// the last checksum period has no closing edge in single shot
		void'(exp_q.pop_back());
		chk(i_rx.per_q.size(), exp_q.size());
		foreach (exp_q[i])
			chk(i_rx.per_q[i], exp_q[i]);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[5:4], 2'h1);
		apb(1'b0, OFS_FLAGS, 32'h0);
		chk(rd[3], 1'b0);
		apb(1'b1, OFS_CONFIG, 32'h1);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, stop_req, clr} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		errors = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		s_reset();
		s_run(9'h072, 14'h1, 32'h9472_5a3c, 32'h1f0e_d2b6, 1'b1);
		for (int k = 0; k < 4; k++)
			s_run({k[1], k[0], 1'b0, 3'(k + 1), 3'h2}, 14'h0, 32'hb6e1_8d47, 32'h0, 1'b0);
		s_stop();
		s_single();
		report_and_stop();
	end
endmodule
